// *** core/cs_wait_pkg.sv ***
// constants for the chip select and wait controller
package cs_wait_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register byte addresses
   localparam logic [31:0] SPACE0_BASE_MASK_ADDR     = 32'hffffe400;
   localparam logic [31:0] SPACE1_BASE_MASK_ADDR     = 32'hffffe404;
   localparam logic [31:0] SPACE2_BASE_MASK_ADDR     = 32'hffffe408;
   localparam logic [31:0] SPACE3_BASE_MASK_ADDR     = 32'hffffe40c;
   localparam logic [31:0] SPACE01_ACCESS_CTRL_ADDR  = 32'hffffe480;
   localparam logic [31:0] SPACE23_ACCESS_CTRL_ADDR  = 32'hffffe484;
   localparam logic [31:0] DEFAULT_ACCESS_CTRL_ADDR  = 32'hffffe488;
   localparam logic [31:0] CYCLE_STATUS_ADDR         = 32'hffffe48c;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [31:0] SPACE01_BASE_MASK_RESET   = 32'h000003ff;
   localparam logic [31:0] SPACE23_BASE_MASK_RESET   = 32'h000001ff;
   localparam logic [31:0] SPACE01_ACCESS_RESET      = 32'h00050005;
   localparam logic [31:0] SPACE23_ACCESS_RESET      = 32'h00050805;
   localparam logic [31:0] DEFAULT_ACCESS_RESET      = 32'h00000005;

   ////////////////////////////////////////////////////////////////////////////
   // field positions inside one 16-bit half of an access control word
   localparam int WAIT_LSB       = 0;
   localparam int WIDTH_BIT      = 4;
   localparam int WAVEFORM_LSB   = 6;
   localparam int RECOVERY_LSB   = 8;
   localparam int SCOPE_BIT      = 10;
   localparam int ENABLE_BIT     = 11;
   localparam int UPPER_HALF_LSB = 16;
   localparam int BASE_LSB       = 16;

   // lowest address bit that a mask field covers
   localparam int LOW_MASK_BIT_01 = 14;
   localparam int LOW_MASK_BIT_23 = 15;

   ////////////////////////////////////////////////////////////////////////////
   // fixed address windows
   localparam logic [12:0] ROM_WINDOW_TAG     = 13'h03f8;
   localparam logic [17:0] EXCLUDED_TAG       = 18'h3fffe;
   localparam logic [3:0]  WAIT_EXTERNAL_CODE = 4'hf;
   localparam logic [3:0]  WAIT_MAX_FIXED     = 4'h7;
   localparam logic [3:0]  WAIT_EXTERNAL_BASE = 4'h1;
   // extra extension cycles so the wait synchroniser catches up;
   // limitation: the memory must pull the pin in the first select cycle
   localparam logic [3:0]  WAIT_SYNC_SETTLE   = 4'h2;

   typedef enum logic [1:0] {
      CYC_IDLE,
      CYC_ACCESS,
      CYC_EXTEND,
      CYC_RECOVER
   } cycle_state_t;

endpackage : cs_wait_pkg

// *** core/space_match.sv ***
// base and mask address match for one chip select space
`timescale 1ns/1ps
`default_nettype none
module space_match #(
   parameter int LOW_BIT = 14
) (
   input  wire logic [31:0] addr,
   input  wire logic [15:0] baseField,
   input  wire logic [15:0] maskField,
   output logic             hit
);

   if (LOW_BIT < 14 || LOW_BIT > 16) begin : badLowBit
      $error("space_match: LOW_BIT out of range");
   end

   wire logic [31:0] baseAddr = {baseField, 16'h0000};
   wire logic [31:0] maskAddr = {16'h0000, maskField} << LOW_BIT;
   wire logic [31:0] keepBits = 32'hffffffff << LOW_BIT;
   // set mask bits drop out of the compare, bits below LOW_BIT never count
   assign hit = (((addr ^ baseAddr) & ~maskAddr & keepBits) == 32'h00000000);

endmodule : space_match
`default_nettype wire

// *** core/cycle_timer.sv ***
// loadable down counter for wait and recovery cycles
`timescale 1ns/1ps
`default_nettype none
module cycle_timer #(
   parameter int WIDTH = 4
) (
   input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] loadValue,
   output logic                  expired
);

   if (WIDTH < 2) begin : badWidth
      $error("cycle_timer: WIDTH too small");
   end

   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] count_next;

   assign count_next = load ? loadValue :
                       (count_reg != '0) ? count_reg - 1'b1 : count_reg;
   assign expired    = (count_reg == '0);

   always_ff @(posedge clock or posedge reset) begin
      if (reset) count_reg <= '0;
      else       count_reg <= count_next;
   end

endmodule : cycle_timer
`default_nettype wire

// *** core/chip_select_wait_control.sv ***
// chip select decode, wait state and recovery timing for external memory
//
// Summary of operation
// - every cycle address is compared to each space base only on bits whose mask bit is clear.
// - the base field gives address bits 31 to 16 and the low sixteen bits are zero.
// - spaces two and three always compare bit 31; software keeps mask bits 15 to 9 clear.
// - the on-chip ROM half megabyte never raises chip select two.
// - no chip select is ever raised between ffff_8000 and ffff_bfff.
// - only one chip select is raised, line zero winning over one, two and three.
// - block sizes are powers of two in the supported range and software keeps to them.
// - settings come from the matching pair register, or the default area when no enabled line is picked.
// - wait codes 0 to 7 insert that many waits; code f inserts four plus the wait pin time.
// - the width bit selects a 16-bit bus when clear and an 8-bit bus when set.
// - recovery code 00 gives two dummy cycles, 01 one and 10 none; 11 is not programmed.
// - the enable bit gates each line; after reset only space two is enabled.
// - the space two scope bit picks whole address space when clear, its own range when set.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module chip_select_wait_control (
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic [31:0] regAddr,
   input  wire logic [31:0] regWrData,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [31:0] regRdData,
   input  wire logic        cycReq,
   input  wire logic [31:0] cycAddr,
   output logic             cycReady,
   output logic             cycDone,
   input  wire logic        waitInN,
   output logic      [3:0]  selectOutN,
   output logic             width8
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [3:0] fixedWaits(input logic [3:0] code);
      // undefined codes 8..e saturate at the longest fixed wait
      if (code == cs_wait_pkg::WAIT_EXTERNAL_CODE)   fixedWaits = cs_wait_pkg::WAIT_EXTERNAL_BASE;
      else if (code > cs_wait_pkg::WAIT_MAX_FIXED)   fixedWaits = cs_wait_pkg::WAIT_MAX_FIXED;
      else                                           fixedWaits = code;
   endfunction : fixedWaits

   function automatic logic [1:0] dummyCycles(input logic [1:0] code);
      case (code)
         2'h0:    dummyCycles = 2'h2;
         2'h1:    dummyCycles = 2'h1;
         2'h2:    dummyCycles = 2'h0;
         default: dummyCycles = 2'h2;   // forbidden code, take the safest spacing
      endcase
   endfunction : dummyCycles

   ////////////////////////////////////////////////////////////////////////////
   // register file

   logic [31:0] baseMask0_reg;
   logic [31:0] baseMask1_reg;
   logic [31:0] baseMask2_reg;
   logic [31:0] baseMask3_reg;
   logic [31:0] space01Ctrl_reg;
   logic [31:0] space23Ctrl_reg;
   logic [31:0] defaultCtrl_reg;
   logic [31:0] regRdData_reg;
   logic [31:0] regRdData_next;

   wire logic hitBm0     = (regAddr == cs_wait_pkg::SPACE0_BASE_MASK_ADDR);
   wire logic hitBm1     = (regAddr == cs_wait_pkg::SPACE1_BASE_MASK_ADDR);
   wire logic hitBm2     = (regAddr == cs_wait_pkg::SPACE2_BASE_MASK_ADDR);
   wire logic hitBm3     = (regAddr == cs_wait_pkg::SPACE3_BASE_MASK_ADDR);
   wire logic hitCtrl01  = (regAddr == cs_wait_pkg::SPACE01_ACCESS_CTRL_ADDR);
   wire logic hitCtrl23  = (regAddr == cs_wait_pkg::SPACE23_ACCESS_CTRL_ADDR);
   wire logic hitCtrlDef = (regAddr == cs_wait_pkg::DEFAULT_ACCESS_CTRL_ADDR);
   wire logic hitStatus  = (regAddr == cs_wait_pkg::CYCLE_STATUS_ADDR);

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         baseMask0_reg   <= cs_wait_pkg::SPACE01_BASE_MASK_RESET;
         baseMask1_reg   <= cs_wait_pkg::SPACE01_BASE_MASK_RESET;
         baseMask2_reg   <= cs_wait_pkg::SPACE23_BASE_MASK_RESET;
         baseMask3_reg   <= cs_wait_pkg::SPACE23_BASE_MASK_RESET;
         space01Ctrl_reg <= cs_wait_pkg::SPACE01_ACCESS_RESET;
         space23Ctrl_reg <= cs_wait_pkg::SPACE23_ACCESS_RESET;
         defaultCtrl_reg <= cs_wait_pkg::DEFAULT_ACCESS_RESET;
      end else if (regWr) begin
         if (hitBm0)     baseMask0_reg   <= regWrData;
         if (hitBm1)     baseMask1_reg   <= regWrData;
         if (hitBm2)     baseMask2_reg   <= regWrData;
         if (hitBm3)     baseMask3_reg   <= regWrData;
         if (hitCtrl01)  space01Ctrl_reg <= regWrData;
         if (hitCtrl23)  space23Ctrl_reg <= regWrData;
         if (hitCtrlDef) defaultCtrl_reg <= regWrData;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // wait pin synchroniser, a change counts once stages two and three agree

   logic waitSync1_reg;
   logic waitSync2_reg;
   logic waitSync3_reg;
   logic waitActive_reg;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         waitSync1_reg  <= 1'b1;
         waitSync2_reg  <= 1'b1;
         waitSync3_reg  <= 1'b1;
         waitActive_reg <= 1'b0;
      end else begin
         waitSync1_reg <= waitInN;
         waitSync2_reg <= waitSync1_reg;
         waitSync3_reg <= waitSync2_reg;
         if (waitSync2_reg == waitSync3_reg) waitActive_reg <= ~waitSync3_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // address decode

   logic [3:0] rangeHit;

   space_match #(.LOW_BIT(cs_wait_pkg::LOW_MASK_BIT_01)) match0 (
      .addr      (cycAddr),
      .baseField (baseMask0_reg[31:16]),
      .maskField (baseMask0_reg[15:0]),
      .hit       (rangeHit[0])
   );
   space_match #(.LOW_BIT(cs_wait_pkg::LOW_MASK_BIT_01)) match1 (
      .addr      (cycAddr),
      .baseField (baseMask1_reg[31:16]),
      .maskField (baseMask1_reg[15:0]),
      .hit       (rangeHit[1])
   );
   // the 16-bit mask reaches only bit 30 here, so bit 31 is always compared
   space_match #(.LOW_BIT(cs_wait_pkg::LOW_MASK_BIT_23)) match2 (
      .addr      (cycAddr),
      .baseField (baseMask2_reg[31:16]),
      .maskField (baseMask2_reg[15:0]),
      .hit       (rangeHit[2])
   );
   space_match #(.LOW_BIT(cs_wait_pkg::LOW_MASK_BIT_23)) match3 (
      .addr      (cycAddr),
      .baseField (baseMask3_reg[31:16]),
      .maskField (baseMask3_reg[15:0]),
      .hit       (rangeHit[3])
   );

   wire logic [15:0] half0   = space01Ctrl_reg[15:0];
   wire logic [15:0] half1   = space01Ctrl_reg[31:16];
   wire logic [15:0] half2   = space23Ctrl_reg[15:0];
   wire logic [15:0] half3   = space23Ctrl_reg[31:16];
   wire logic [15:0] halfDef = defaultCtrl_reg[15:0];

   wire logic inRomWindow  = (cycAddr[31:19] == cs_wait_pkg::ROM_WINDOW_TAG);
   wire logic inExcluded   = (cycAddr[31:14] == cs_wait_pkg::EXCLUDED_TAG);
   wire logic scope2Range  = half2[cs_wait_pkg::SCOPE_BIT];
   wire logic space2Region = scope2Range ? rangeHit[2] : 1'b1;

   wire logic cand0 = rangeHit[0] & half0[cs_wait_pkg::ENABLE_BIT];
   wire logic cand1 = rangeHit[1] & half1[cs_wait_pkg::ENABLE_BIT];
   wire logic cand2 = space2Region & ~inRomWindow & half2[cs_wait_pkg::ENABLE_BIT];
   wire logic cand3 = rangeHit[3] & half3[cs_wait_pkg::ENABLE_BIT];

   // one line at most, line zero first
   wire logic pick0 = ~inExcluded & cand0;
   wire logic pick1 = ~inExcluded & ~cand0 & cand1;
   wire logic pick2 = ~inExcluded & ~cand0 & ~cand1 & cand2;
   wire logic pick3 = ~inExcluded & ~cand0 & ~cand1 & ~cand2 & cand3;
   wire logic [3:0] pickVec = {pick3, pick2, pick1, pick0};

   // settings of the chosen space, or of the default area
   wire logic [15:0] chosenHalf = pick0 ? half0 :
                                  pick1 ? half1 :
                                  pick2 ? half2 :
                                  pick3 ? half3 : halfDef;

   wire logic [3:0] chosenWaitCode = chosenHalf[cs_wait_pkg::WAIT_LSB +: 4];
   wire logic [1:0] chosenRcvCode  = chosenHalf[cs_wait_pkg::RECOVERY_LSB +: 2];
   wire logic       chosenWidth8   = chosenHalf[cs_wait_pkg::WIDTH_BIT];
   wire logic       chosenExtend   = (chosenWaitCode == cs_wait_pkg::WAIT_EXTERNAL_CODE);

   ////////////////////////////////////////////////////////////////////////////
   // bus cycle sequencer

   cs_wait_pkg::cycle_state_t state_reg;
   cs_wait_pkg::cycle_state_t state_next;

   logic       extend_reg;
   logic       extend_next;
   logic [1:0] rcvCycles_reg;
   logic [1:0] rcvCycles_next;
   logic [3:0] selectOutN_reg;
   logic [3:0] selectOutN_next;
   logic       width8_reg;
   logic       width8_next;
   logic       cycDone_reg;
   logic       cycDone_next;
   logic       cycReady_reg;
   logic       cycReady_next;
   logic [1:0] lastSpace_reg;
   logic [1:0] lastSpace_next;
   logic       lastDefault_reg;
   logic       lastDefault_next;
   logic       timerLoad;
   logic [3:0] timerValue;
   logic       timerExpired;

   cycle_timer #(.WIDTH(4)) timer (
      .clock     (clock),
      .reset     (reset),
      .load      (timerLoad),
      .loadValue (timerValue),
      .expired   (timerExpired)
   );

   wire logic       startCycle  = (state_reg == cs_wait_pkg::CYC_IDLE) & cycReq;
   wire logic       accessEnd   = (state_reg == cs_wait_pkg::CYC_ACCESS) & timerExpired & ~extend_reg;
   wire logic       extendEnd   = (state_reg == cs_wait_pkg::CYC_EXTEND) & timerExpired &
                                  ~waitActive_reg;
   wire logic       cycleEnd    = accessEnd | extendEnd;
   wire logic       rcvEnd      = (state_reg == cs_wait_pkg::CYC_RECOVER) & timerExpired;
   // a zero recovery count skips the dummy state entirely
   wire logic [3:0] rcvLoad     = (rcvCycles_reg == 2'h0) ? 4'h0 : {2'h0, rcvCycles_reg - 2'h1};
   wire logic [1:0] pickIndex   = pick1 ? 2'h1 : pick2 ? 2'h2 : pick3 ? 2'h3 : 2'h0;

   always_comb begin
      state_next       = state_reg;
      extend_next      = extend_reg;
      rcvCycles_next   = rcvCycles_reg;
      selectOutN_next  = selectOutN_reg;
      width8_next      = width8_reg;
      cycDone_next     = cycleEnd;
      lastSpace_next   = lastSpace_reg;
      lastDefault_next = lastDefault_reg;
      timerLoad        = 1'b0;
      timerValue       = 4'h0;
      case (state_reg)
         cs_wait_pkg::CYC_IDLE: begin
            if (startCycle) begin
               state_next       = cs_wait_pkg::CYC_ACCESS;
               selectOutN_next  = ~pickVec;
               width8_next      = chosenWidth8;
               extend_next      = chosenExtend;
               rcvCycles_next   = dummyCycles(chosenRcvCode);
               lastSpace_next   = pickIndex;
               lastDefault_next = (pickVec == 4'h0);
               timerLoad        = 1'b1;
               timerValue       = fixedWaits(chosenWaitCode);
            end
         end
         cs_wait_pkg::CYC_ACCESS: begin
            if (timerExpired) begin
               if (extend_reg) begin
                  // a pin pulled low with the select takes four clocks to show
                  state_next = cs_wait_pkg::CYC_EXTEND;
                  timerLoad  = 1'b1;
                  timerValue = cs_wait_pkg::WAIT_SYNC_SETTLE;
               end else begin
                  state_next      = (rcvCycles_reg == 2'h0) ? cs_wait_pkg::CYC_IDLE
                                                            : cs_wait_pkg::CYC_RECOVER;
                  selectOutN_next = 4'hf;
                  timerLoad       = 1'b1;
                  timerValue      = rcvLoad;
               end
            end
         end
         cs_wait_pkg::CYC_EXTEND: begin
            // held for as long as the memory pulls the wait pin
            if (extendEnd) begin
               state_next      = (rcvCycles_reg == 2'h0) ? cs_wait_pkg::CYC_IDLE
                                                         : cs_wait_pkg::CYC_RECOVER;
               selectOutN_next = 4'hf;
               timerLoad       = 1'b1;
               timerValue      = rcvLoad;
            end
         end
         cs_wait_pkg::CYC_RECOVER: begin
            if (rcvEnd) state_next = cs_wait_pkg::CYC_IDLE;
         end
         default: begin
            state_next      = cs_wait_pkg::CYC_IDLE;
            selectOutN_next = 4'hf;
         end
      endcase
      cycReady_next = (state_next == cs_wait_pkg::CYC_IDLE);
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_reg       <= cs_wait_pkg::CYC_IDLE;
         extend_reg      <= 1'b0;
         rcvCycles_reg   <= 2'h0;
         selectOutN_reg  <= 4'hf;
         width8_reg      <= 1'b0;
         cycDone_reg     <= 1'b0;
         cycReady_reg    <= 1'b1;
         lastSpace_reg   <= 2'h0;
         lastDefault_reg <= 1'b0;
      end else begin
         state_reg       <= state_next;
         extend_reg      <= extend_next;
         rcvCycles_reg   <= rcvCycles_next;
         selectOutN_reg  <= selectOutN_next;
         width8_reg      <= width8_next;
         cycDone_reg     <= cycDone_next;
         cycReady_reg    <= cycReady_next;
         lastSpace_reg   <= lastSpace_next;
         lastDefault_reg <= lastDefault_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path, access control words are write only and read as zero

   wire logic [31:0] statusWord = {21'h00000, lastDefault_reg, lastSpace_reg,
                                   waitActive_reg, (state_reg == cs_wait_pkg::CYC_EXTEND),
                                   ~cycReady_reg, width8_reg, ~selectOutN_reg};

   assign regRdData_next = !regRd    ? 32'h00000000  :
                           hitBm0    ? baseMask0_reg :
                           hitBm1    ? baseMask1_reg :
                           hitBm2    ? baseMask2_reg :
                           hitBm3    ? baseMask3_reg :
                           hitStatus ? statusWord    : 32'h00000000;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) regRdData_reg <= 32'h00000000;
      else       regRdData_reg <= regRdData_next;
   end

   assign regRdData  = regRdData_reg;
   assign selectOutN = selectOutN_reg;
   assign width8     = width8_reg;
   assign cycDone    = cycDone_reg;
   assign cycReady   = cycReady_reg;

endmodule : chip_select_wait_control
`default_nettype wire

// *** tb/cs_wait_chk.sv ***
// port assertions for the chip select and wait controller
`timescale 1ns/1ps
`default_nettype none
module cs_wait_chk (
   input wire logic        clock,
   input wire logic        reset,
   input wire logic [31:0] regAddr,
   input wire logic        regRd,
   input wire logic [31:0] regRdData,
   input wire logic        cycReq,
   input wire logic [31:0] cycAddr,
   input wire logic        cycReady,
   input wire logic        cycDone,
   input wire logic [3:0]  selectOutN,
   input wire logic        width8
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   ////////////////////////////////////////
   sequence s_start; cycReq && cycReady; endsequence
   sequence s_release; selectOutN == 4'hf ##1 !cycDone; endsequence
   property p_onehot; $onehot0(~selectOutN); endproperty
   a_onehot: assert property (p_onehot) else $error("two selects low");
   property p_excl; s_start ##0 (cycAddr[31:14] == 18'h3fffe) |=> selectOutN == 4'hf; endproperty
   a_excl: assert property (p_excl) else $error("select in excluded range");
   property p_rom; s_start ##0 (cycAddr[31:19] == 13'h03f8) |=> selectOutN[2]; endproperty
   a_rom: assert property (p_rom) else $error("space two in rom window");
   property p_busy; s_start |=> !cycReady && !cycDone; endproperty
   a_busy: assert property (p_busy) else $error("not busy after start");
   // partner wait is short, so sixty cycles bounds every code
   property p_bound; s_start |=> ##[1:60] cycDone; endproperty
   a_bound: assert property (p_bound) else $error("cycle never ends");
   property p_release; cycDone |-> s_release; endproperty
   a_release: assert property (p_release) else $error("select held at done");
   property p_hold;
      selectOutN != 4'hf |=> (selectOutN == $past(selectOutN) && $stable(width8)) || cycDone;
   endproperty
   a_hold: assert property (p_hold) else $error("select or width moved");
   property p_rdidle; !regRd |=> regRdData == 32'h0; endproperty
   a_rdidle: assert property (p_rdidle) else $error("read data without read");
   property p_wo; regRd && regAddr[31:4] == 28'hffffe48 && regAddr[3:0] != 4'hc
      |=> regRdData == 32'h0; endproperty
   a_wo: assert property (p_wo) else $error("control word readable");
endmodule : cs_wait_chk
`default_nettype wire

// *** tb/mem_model.sv ***
// external memory: holds the wait pin low early in each select
`timescale 1ns/1ps
`default_nettype none
module mem_model (
   input  wire logic       clock,
   input  wire logic [3:0] selectOutN,
   input  wire logic [7:0] holdLen,
   output logic            waitInN
);
   logic [7:0] selCount;
   // pin is pulled up, so released means high
   assign waitInN = &selectOutN || selCount >= holdLen;
   always_ff @(posedge clock) begin
      if (&selectOutN) selCount <= 8'h0;
      else if (selCount != 8'hff) selCount <= selCount + 8'h1;
   end
endmodule : mem_model
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the chip select and wait controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clock;
   logic        reset;
   logic [31:0] regAddr;
   logic [31:0] regWrData;
   logic        regWr;
   logic        regRd;
   logic [31:0] regRdData;
   logic        cycReq;
   logic [31:0] cycAddr;
   logic        cycReady;
   logic        cycDone;
   logic        waitInN;
   logic [3:0]  selectOutN;
   logic        width8;
   logic [7:0]  holdLen;
   int          errCount = 0;
   int          checked = 0;
   chip_select_wait_control i_chip_select_wait_control (.clock(clock), .reset(reset),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .cycReq(cycReq), .cycAddr(cycAddr), .cycReady(cycReady),
      .cycDone(cycDone), .waitInN(waitInN), .selectOutN(selectOutN), .width8(width8));
   mem_model i_mem_model (.clock(clock), .selectOutN(selectOutN), .holdLen(holdLen),
      .waitInN(waitInN));
   ////////////////////////////////////////
   task automatic endOfTest;
      $display("checks %0d errors %0d", checked, errCount);
      if (errCount == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : endOfTest
   task automatic fail(input string m);
      errCount++;
      $display("wrong value at %0t: %s", $time, m);
   endtask : fail
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp) fail(m);
   endtask : chk
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clock);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clock);
      regWr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      @(posedge clock);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRd <= 1'b0;
      #1 chk(regRdData, exp, "read data");
   endtask : rd
   // lo..hi bounds the edge of done after the taking edge; d is the idle gap
   task automatic cyc(input logic [31:0] a, input logic [3:0] sel, input int lo, input int hi,
                      input int d, input logic w8);
      int n;
      int r;
      n = 0;
      r = 0;
      @(posedge clock);
      cycReq <= 1'b1;
      cycAddr <= a;
      @(posedge clock);
      cycReq <= 1'b0;
      #1 chk(32'(selectOutN), 32'(sel), "select line");
      chk(32'(width8), 32'(w8), "bus width");
      do begin
         @(posedge clock);
         #1 n++;
      end while (cycDone !== 1'b1 && n < 60);
      checked++;
      if (n < lo || n > hi) fail("done timing");
      while (cycReady !== 1'b1 && r < 9) begin
         @(posedge clock);
         #1 r++;
      end
      chk(32'(r), 32'(d), "recovery gap");
      if (n >= 60 || r >= 9) endOfTest();
   endtask : cyc
   ////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      reset = 1'b1;
      {regAddr, regWrData, regWr, regRd, cycReq, cycAddr} = '0;
      holdLen = 8'h0;
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      rd(32'hffffe400, 32'h000003ff);
      rd(32'hffffe408, 32'h000001ff);
      rd(32'hffffe480, 32'h0);
      rd(32'hffffe490, 32'h0);
      cyc(32'h00001000, 4'hb, 6, 6, 2, 1'b0);
      cyc(32'h1fc00000, 4'hf, 6, 6, 2, 1'b0);
      cyc(32'hffff8000, 4'hf, 6, 6, 2, 1'b0);
      cyc(32'hffffbfff, 4'hf, 6, 6, 2, 1'b0);
      cyc(32'hffffc000, 4'hb, 6, 6, 2, 1'b0);
      wr(32'hffffe400, 32'hc0000000);
      wr(32'hffffe404, 32'hc0000003);
      wr(32'hffffe480, 32'h09030a10);
      cyc(32'hc0000000, 4'he, 1, 1, 0, 1'b1);
      cyc(32'hc0003fff, 4'he, 1, 1, 0, 1'b1);
      cyc(32'hc0004000, 4'hd, 4, 4, 1, 1'b0);
      cyc(32'hc0010000, 4'hb, 6, 6, 2, 1'b0);
      wr(32'hffffe408, 32'h1fc8000f);
      wr(32'hffffe484, 32'h00000c02);
      cyc(32'h1fcfffff, 4'hb, 3, 3, 2, 1'b0);
      cyc(32'h1fd00000, 4'hf, 6, 6, 2, 1'b0);
      rd(32'hffffe48c, 32'h00000400);
      for (int i = 0; i < 3; i++) begin
         wr(32'hffffe488, 32'h00000010 | (i << 8));
         cyc(32'h00001000, 4'hf, 1, 1, 2 - i, 1'b1);
      end
      holdLen <= 8'd12;
      wr(32'hffffe488, 32'h0000020f);
      cyc(32'h00001000, 4'hf, 5, 5, 0, 1'b0);
      wr(32'hffffe484, 32'h00000c0f);
      cyc(32'h1fc80000, 4'hb, 17, 17, 2, 1'b0);
      wr(32'hffffe480, 32'h0);
      wr(32'hffffe484, 32'h0);
      cyc(32'hc0000000, 4'hf, 5, 5, 0, 1'b0);
      cyc(32'h1fc80000, 4'hf, 5, 5, 0, 1'b0);
      endOfTest();
   end
endmodule : tb_top
bind chip_select_wait_control cs_wait_chk i_cs_wait_chk (.clock(clock), .reset(reset),
   .regAddr(regAddr), .regRd(regRd), .regRdData(regRdData), .cycReq(cycReq),
   .cycAddr(cycAddr), .cycReady(cycReady), .cycDone(cycDone), .selectOutN(selectOutN),
   .width8(width8));
`default_nettype wire
